/* File: rtl/timer_ppg_oneshot_capture.sv */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "timer_cfg.svh"

// Function
// - Mode 11 restarts counter on cycle match and drives a pulse train on output.
// - Pulse-generator period is cycle value plus one count clocks.
// - Pulse-generator high time is width value plus one count clocks.
// - Pulse-generator cycle match raises compare interrupt zero and clears counter.
// - Pulse-generator width match raises compare interrupt one, counter keeps running.
// - One-shot allowed only in modes 01 or 10 with one-shot enable set.
// - Trigger bit or valid edge on input a restarts counter, emits one pulse.
// - One-shot cycle match raises interrupt zero and inverts the output.
// - One-shot width match raises interrupt one and inverts the output.
// - One-shot output goes active after M+1 counts, stays N-M counts.
// - Mode 01: edge on input a captures to width, input b to cycle.
// - Single-input free-run: opposite edge captures cycle, valid edge captures width.
// - Mode 10: valid edge captures width then clears counter; opposite edge captures cycle.
// - Overflow flag holds until software clears it; set beats clear.
// - Cycle capture source selectable as input a or b; width always input a.
// - Opposite-edge capture into cycle register raises no interrupt zero.
// - Free-running counter wraps from FFFF to 0000 and sets overflow.
// - Counter stopped in mode 00, runs in every other mode.
// - Capture on a count clock, its interrupt on the following count clock.
module timer_ppg_oneshot_capture
	import timer_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic [`ADDR_W-1:0]  reg_addr,
	input  wire logic [15:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [15:0]         reg_rdata,
	input  wire logic                capture_input_a,
	input  wire logic                capture_input_b,
	output logic                     timer_out_pin,
	output logic                     match_irq_zero,
	output logic                     match_irq_one
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release

	reset_sync_t  rs_q;
	logic         rst_int_b;

	// Assert at once, release through two flops so no flop sees a ragged edge
	// Limitation: counting can begin only two core clocks after the pin rises
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rs_q <= '0;
		else
			rs_q <= '{rst_meta: 1'b1, rst_sync: rs_q.rst_meta};
	end

	assign rst_int_b = rs_q.rst_sync;

	////////////////////////////////////////////////////////////////////////////////
	// Edge qualifier shared by both capture inputs
	// With both edges selected there is no opposite edge, so it never fires

	function automatic logic edge_hit(
		input logic       prev,
		input logic       cur,
		input logic [1:0] sel,
		input logic       opp
	);
		logic rise;
		logic fall;
		logic hit;
		rise = !prev && cur;
		fall = prev && !cur;
		case (sel)
			`EDGE_FALL: hit = opp ? rise : fall;
			`EDGE_RISE: hit = opp ? fall : rise;
			`EDGE_BOTH: hit = opp ? 1'b0 : (rise || fall);
			default:    hit = 1'b0;
		endcase
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	timer_state_t s_q;
	timer_state_t s_d;

	logic        tick;
	logic [6:0]  div_lim;
	logic [15:0] next_cnt;
	logic        m_cyc;
	logic        m_wid;
	logic        os_mode;
	logic        os_start;
	logic        cyc_src;
	logic [1:0]  sel_a;
	logic [1:0]  sel_b;
	logic        hit_a_valid;
	logic        hit_a_opp;
	logic        hit_b_valid;
	logic        trig_wr;

	// Count clock is a one-cycle enable every 2^n core clocks
	// Seven divider bits cover the largest prescale of 2^7 core clocks
	// The divider only runs while the counter runs, so a start is always aligned
	assign div_lim = 7'((8'h01 << s_q.prescaler_mode_reg[`PRM_DIV_MSB:`PRM_DIV_LSB]) - 8'h01);
	assign tick    = (s_q.mode != `MODE_STOP) && (s_q.div == div_lim);
	assign sel_a   = s_q.prescaler_mode_reg[`PRM_EA_MSB:`PRM_EA_LSB];
	assign sel_b   = s_q.prescaler_mode_reg[`PRM_EB_MSB:`PRM_EB_LSB];

	// Pin edges and the trigger strobe of this core clock, seen before any tick
	assign hit_a_valid = edge_hit(s_q.prev_a, capture_input_a, sel_a, 1'b0);
	assign hit_a_opp   = edge_hit(s_q.prev_a, capture_input_a, sel_a, 1'b1);
	assign hit_b_valid = edge_hit(s_q.prev_b, capture_input_b, sel_b, 1'b0);
	assign trig_wr     = reg_wr && (reg_addr == `A_TOC) && reg_wdata[`TOC_OS_TRIG];

	// One-shot only exists in free-running and edge-restart modes
	assign os_mode = s_q.output_control_reg[`TOC_OS_EN] &&
		((s_q.mode == `MODE_FREE) || (s_q.mode == `MODE_EDGE));

	// Next state: bus writes first, then pin edges, then the work of a count clock
	always_comb
	begin
		s_d      = s_q;
		next_cnt = s_q.up_counter + `CNT_ONE;
		m_cyc    = 1'b0;
		m_wid    = 1'b0;
		os_start = 1'b0;
		cyc_src  = 1'b0;
		s_d.irq0    = 1'b0;
		s_d.irq1    = 1'b0;
		s_d.rd_data = `RST_REG16;

		// Register writes; hardware updates below override where they collide
		// The counter index is read only; a write to it falls to the default arm
		if (reg_wr)
		begin
			unique case (reg_addr)
				`A_CYCLE:
					s_d.cycle_register = reg_wdata;
				`A_WIDTH:
					s_d.width_register = reg_wdata;
				`A_MODE:
				begin
					s_d.mode          = reg_wdata[`MODE_MSB:`MODE_LSB];
					s_d.overflow_flag = reg_wdata[`OVF_BIT];
				end
				`A_CRC:
					s_d.capture_compare_ctrl = reg_wdata[`CRC_W-1:0];
				`A_TOC:
				begin
					s_d.output_control_reg = reg_wdata[`TOC_W-1:0];
					// Trigger bit is a strobe: remembered until the next count clock
					if (reg_wdata[`TOC_OS_TRIG])
						s_d.trig_pend = 1'b1;
					// Manual level set/clear only while the counter is stopped
					if (s_q.mode == `MODE_STOP && reg_wdata[`TOC_LVL_SET] &&
						!reg_wdata[`TOC_LVL_RST])
						s_d.out_level = 1'b1;
					if (s_q.mode == `MODE_STOP && reg_wdata[`TOC_LVL_RST] &&
						!reg_wdata[`TOC_LVL_SET])
						s_d.out_level = 1'b0;
				end
				`A_PRM:
					s_d.prescaler_mode_reg = reg_wdata[7:0];
				default:
					s_d.rd_data = s_d.rd_data;
			endcase
		end

		// Read data stands only in the cycle after the strobe
		// The trigger bit is not stored, so it reads back as zero
		if (reg_rd)
		begin
			unique case (reg_addr)
				`A_COUNTER: s_d.rd_data = s_q.up_counter;
				`A_CYCLE:   s_d.rd_data = s_q.cycle_register;
				`A_WIDTH:   s_d.rd_data = s_q.width_register;
				`A_MODE:    s_d.rd_data = {12'h000, s_q.mode, 1'b0, s_q.overflow_flag};
				`A_CRC:     s_d.rd_data = {13'h0000, s_q.capture_compare_ctrl};
				`A_TOC:     s_d.rd_data = {10'h000, s_q.output_control_reg};
				`A_PRM:     s_d.rd_data = {8'h00, s_q.prescaler_mode_reg};
				default:    s_d.rd_data = `RST_REG16;
			endcase
		end

		// Edges are caught every core clock and held until the count clock
		// Caught edges are dropped only in mode 00, where the counter is stopped, never on a slow count clock
		s_d.prev_a = capture_input_a;
		s_d.prev_b = capture_input_b;
		if (hit_a_valid)
			s_d.pend_a_valid = 1'b1;
		if (hit_a_opp)
			s_d.pend_a_opp = 1'b1;
		if (hit_b_valid)
			s_d.pend_b_valid = 1'b1;

		if (s_q.mode == `MODE_STOP)
		begin
			// Stopped: counter parked at zero, no edge or interrupt pending; a trigger strobe stays pending
			s_d.up_counter   = `CNT_ZERO;
			s_d.div          = `DIV_ZERO;
			s_d.pend_a_valid = 1'b0;
			s_d.pend_a_opp   = 1'b0;
			s_d.pend_b_valid = 1'b0;
			s_d.irq0_pend    = 1'b0;
			s_d.irq1_pend    = 1'b0;
			s_d.os_phase     = OS_IDLE;
		end
		else if (!tick)
			s_d.div = s_q.div + `DIV_ONE;
		else
		begin
			s_d.div = `DIV_ZERO;

			// Interrupts of last count clock's captures come out now
			s_d.irq0      = s_q.irq0_pend;
			s_d.irq1      = s_q.irq1_pend;
			s_d.irq0_pend = 1'b0;
			s_d.irq1_pend = 1'b0;

			// Compare matches only on registers not used for capture
			// A register in capture use would otherwise match its own captured count
			m_cyc = !s_q.capture_compare_ctrl[`CRC_CYC_CAP] &&
				(s_q.up_counter == s_q.cycle_register);
			m_wid = !s_q.capture_compare_ctrl[`CRC_WID_CAP] &&
				(s_q.up_counter == s_q.width_register);
			if (m_cyc)
				s_d.irq0 = 1'b1;
			if (m_wid)
				s_d.irq1 = 1'b1;

			// Wrap from the top sets overflow, also via a cycle match at FFFF
			if (s_q.up_counter == `CNT_MAX)
				s_d.overflow_flag = 1'b1;

			if (s_q.mode == `MODE_PPG)
			begin
				// Output high from restart through width match: N+1 period, M+1 high
				// Set and clear, not toggle, so a missed match cannot lock it inverted
				if (m_cyc)
				begin
					next_cnt = `CNT_ZERO;
					if (s_q.output_control_reg[`TOC_INV_CYC])
						s_d.out_level = 1'b1;
				end
				if (m_wid && s_q.output_control_reg[`TOC_INV_WID])
					s_d.out_level = 1'b0;
			end
			else if (os_mode)
			begin
				// Either match inverts: first one starts the pulse, second ends it
				// A trigger during a pulse restarts the count but not the level; software must not rely on that
				os_start = s_q.trig_pend || s_q.pend_a_valid;
				if ((m_cyc || m_wid) && s_q.os_phase != OS_IDLE)
				begin
					s_d.out_level = !s_q.out_level;
					s_d.os_phase  = (s_q.os_phase == OS_WAIT) ? OS_ACTIVE : OS_IDLE;
				end
				if (os_start)
				begin
					next_cnt     = `CNT_ZERO;
					s_d.os_phase = OS_WAIT;
				end
			end
			else
			begin
				// Free-running or edge-restart compare: each enabled match toggles the output
				if ((m_cyc && s_q.output_control_reg[`TOC_INV_CYC]) !=
					(m_wid && s_q.output_control_reg[`TOC_INV_WID]))
					s_d.out_level = !s_q.out_level;
			end

			// Width register always captures on the valid edge of input a
			if (s_q.capture_compare_ctrl[`CRC_WID_CAP] && s_q.pend_a_valid)
			begin
				s_d.width_register = s_q.up_counter;
				s_d.irq1_pend      = 1'b1;
			end

			// Cycle register captures on input b or on the opposite edge of input a
			cyc_src = s_q.capture_compare_ctrl[`CRC_CYC_OPP] ? s_q.pend_a_opp
				: s_q.pend_b_valid;
			if (s_q.capture_compare_ctrl[`CRC_CYC_CAP] && cyc_src)
			begin
				s_d.cycle_register = s_q.up_counter;
				// Opposite-phase capture is silent to avoid a spurious event
				if (!s_q.capture_compare_ctrl[`CRC_CYC_OPP])
					s_d.irq0_pend = 1'b1;
			end

			// Edge-restart mode clears after the capture has taken the old count
			if (s_q.mode == `MODE_EDGE && s_q.pend_a_valid)
				next_cnt = `CNT_ZERO;

			s_d.up_counter   = next_cnt;
			// Pending work is used up, but an edge or strobe of this very cycle
			// stays pending: the set wins, else every-cycle counting would lose it
			s_d.trig_pend    = trig_wr;
			s_d.pend_a_valid = hit_a_valid;
			s_d.pend_a_opp   = hit_a_opp;
			s_d.pend_b_valid = hit_b_valid;
		end

		// Pin follows the level only while the output is enabled
		s_d.pin = s_q.output_control_reg[`TOC_PIN_EN] && s_d.out_level;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	// Cleared by the released reset copy, never straight from the pin

	always_ff @(posedge core_clk or negedge rst_int_b)
	begin
		if (!rst_int_b)
		begin
			s_q <= '{
				up_counter:           `CNT_ZERO,
				cycle_register:       `RST_REG16,
				width_register:       `RST_REG16,
				mode:                 `MODE_STOP,
				prescaler_mode_reg:   `RST_PRM,
				div:                  `DIV_ZERO,
				os_phase:             OS_IDLE,
				rd_data:              `RST_REG16,
				default:              1'b0
			};
		end
		else
			s_q <= s_d;
	end

	// Outputs straight from the state flops
	// No gate sits between these flops and the pins, so no output glitches
	assign reg_rdata      = s_q.rd_data;
	assign timer_out_pin  = s_q.pin;
	assign match_irq_zero = s_q.irq0;
	assign match_irq_one  = s_q.irq1;

endmodule // timer_ppg_oneshot_capture

/* File: pkg/timer_cfg.svh */
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register indices on the plain register port
`define ADDR_W          4
`define A_COUNTER       4'h0
`define A_CYCLE         4'h1
`define A_WIDTH         4'h2
`define A_MODE          4'h3
`define A_CRC           4'h4
`define A_TOC           4'h5
`define A_PRM           4'h6

// Mode field values
`define MODE_STOP       2'h0
`define MODE_FREE       2'h1
`define MODE_EDGE       2'h2
`define MODE_PPG        2'h3

// Mode control register fields
`define MODE_LSB        2
`define MODE_MSB        3
`define OVF_BIT         0

// Capture/compare control fields
`define CRC_CYC_CAP     0
`define CRC_CYC_OPP     1
`define CRC_WID_CAP     2
`define CRC_W           3

// Output control fields
`define TOC_PIN_EN      0
`define TOC_INV_CYC     1
`define TOC_LVL_RST     2
`define TOC_LVL_SET     3
`define TOC_INV_WID     4
`define TOC_OS_EN       5
`define TOC_OS_TRIG     6
`define TOC_W           6

// Prescaler mode fields
`define PRM_EA_LSB      0
`define PRM_EA_MSB      1
`define PRM_EB_LSB      2
`define PRM_EB_MSB      3
`define PRM_DIV_LSB     4
`define PRM_DIV_MSB     6

// Edge select codes
`define EDGE_FALL       2'h0
`define EDGE_RISE       2'h1
`define EDGE_BOTH       2'h3

// Counter limits and reset values
`define CNT_ZERO        16'h0000
`define CNT_MAX         16'hFFFF
`define CNT_ONE         16'h0001
`define DIV_ZERO        7'h00
`define DIV_ONE         7'h01
`define RST_REG16       16'h0000
`define RST_PRM         8'h00

`endif

/* File: pkg/timer_pkg.sv */
package timer_pkg;

	// One-shot pulse progress
	typedef enum logic [1:0] {
		OS_IDLE,
		OS_WAIT,
		OS_ACTIVE
	} oneshot_phase_t;

	// Whole state of the timer, registered in one process
	typedef struct packed {
		logic            rst_meta;
		logic            rst_sync;
	} reset_sync_t;

	typedef struct packed {
		logic [15:0]     up_counter;
		logic [15:0]     cycle_register;
		logic [15:0]     width_register;
		logic [1:0]      mode;
		logic            overflow_flag;
		logic [2:0]      capture_compare_ctrl;
		logic [5:0]      output_control_reg;
		logic [7:0]      prescaler_mode_reg;
		logic [6:0]      div;
		logic            prev_a;
		logic            prev_b;
		logic            pend_a_valid;
		logic            pend_a_opp;
		logic            pend_b_valid;
		logic            trig_pend;
		logic            irq0_pend;
		logic            irq1_pend;
		logic            irq0;
		logic            irq1;
		logic            out_level;
		logic            pin;
		oneshot_phase_t  os_phase;
		logic [15:0]     rd_data;
	} timer_state_t;

endpackage

/* File: testbench/timer_props.sv */
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_props
	import timer_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               rst_b,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [15:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [15:0]        reg_rdata,
	input wire logic               capture_input_a,
	input wire logic               capture_input_b,
	input wire logic               timer_out_pin,
	input wire logic               match_irq_zero,
	input wire logic               match_irq_one
);
	logic [15:0] cyc_q, wid_q, gap_q;
	logic [5:0]  toc_q;
	logic [2:0]  div_q, quiet_q;
	logic [1:0]  mode_q;
	logic        seen_q;
	logic        ppg, run_ok, stop_ok;

	////////////////////////////////////////////////////////////
	// Mirror of settings; any write voids the pulse history
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			{cyc_q, wid_q, gap_q, toc_q, div_q, quiet_q, mode_q, seen_q} <= '0;
		else
		begin
			quiet_q <= reg_wr ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
			gap_q <= match_irq_zero ? 16'h0001 : gap_q + 16'h0001;
			seen_q <= !reg_wr && (seen_q || match_irq_zero);
			if (reg_wr && reg_addr == `A_CYCLE)
				cyc_q <= reg_wdata;
			if (reg_wr && reg_addr == `A_WIDTH)
				wid_q <= reg_wdata;
			if (reg_wr && reg_addr == `A_MODE)
				mode_q <= reg_wdata[`MODE_MSB:`MODE_LSB];
			if (reg_wr && reg_addr == `A_TOC)
				toc_q <= reg_wdata[5:0];
			if (reg_wr && reg_addr == `A_PRM)
				div_q <= reg_wdata[`PRM_DIV_MSB:`PRM_DIV_LSB];
		end
	end

	// Count clock equals core clock only with a zero divider
	assign ppg = mode_q == `MODE_PPG && div_q == 3'h0 && seen_q;
	assign run_ok = mode_q == `MODE_FREE && div_q == 3'h0 && !toc_q[5] && quiet_q == 3'h7;
	assign stop_ok = mode_q == `MODE_STOP && quiet_q == 3'h7;

	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence cnt_read_s;
		reg_rd && reg_addr == `A_COUNTER;
	endsequence
	sequence two_reads_s;
		cnt_read_s ##1 cnt_read_s;
	endsequence

	////////////////////////////////////////////////////////////
	cnt_step_a: assert property (run_ok ##0 two_reads_s |=>
		reg_rdata == $past(reg_rdata) + 16'h0001) else $error("counter step wrong");
	stop_hold_a: assert property (stop_ok ##0 two_reads_s |=>
		reg_rdata == $past(reg_rdata)) else $error("counter moved while stopped");
	stop_quiet_a: assert property (stop_ok |-> !match_irq_zero && !match_irq_one)
		else $error("event while stopped");
	ppg_period_a: assert property (ppg && match_irq_zero |-> gap_q == cyc_q + 16'h0001)
		else $error("pulse period wrong");
	ppg_width_a: assert property (ppg && match_irq_one |-> gap_q == wid_q + 16'h0001)
		else $error("width match at wrong count");
	ppg_rise_a: assert property (ppg && toc_q[1:0] == 2'h3 && match_irq_zero |->
		##[0:1] timer_out_pin) else $error("output not raised on cycle match");
	ppg_fall_a: assert property (ppg && toc_q[4] && toc_q[0] && match_irq_one |->
		##[0:1] !timer_out_pin) else $error("output not lowered on width match");
	irq_single_a: assert property (match_irq_zero |=> !match_irq_zero)
		else $error("event zero longer than one cycle");
endmodule // timer_props

bind timer_ppg_oneshot_capture timer_props timer_props_i
(
	.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
	.timer_out_pin(timer_out_pin), .match_irq_zero(match_irq_zero),
	.match_irq_one(match_irq_one)
);

/* File: testbench/pin_model.sv */
`timescale 1ns/1ps
module pin_model
(
	input  wire logic core_clk,
	input  wire logic lvl_a,
	input  wire logic lvl_b,
	output logic      capture_input_a = 1'b0,
	output logic      capture_input_b = 1'b0
);
	// Pins move just after an edge; a stays put unless asked, so no stray trigger
	always @(posedge core_clk)
	begin
		capture_input_a <= lvl_a;
		capture_input_b <= lvl_b;
	end
endmodule // pin_model

/* File: testbench/timer_ppg_oneshot_capture_tb.sv */
`timescale 1ns/1ps
`include "timer_cfg.svh"
module timer_ppg_oneshot_capture_tb;
	logic               core_clk = 1'b0, rst_b = 1'b0;
	logic [`ADDR_W-1:0] reg_addr = '0;
	logic [15:0]        reg_wdata = '0, reg_rdata, v, c, w, t;
	logic               reg_wr = 1'b0, reg_rd = 1'b0, lvl_a = 1'b0, lvl_b = 1'b0;
	logic               capture_input_a, capture_input_b, timer_out_pin;
	logic               match_irq_zero, match_irq_one;
	int                 err_total = 0, num_checks = 0, n0 = 0, n1 = 0, k;

	timer_ppg_oneshot_capture timer_ppg_oneshot_capture_i
	(
		.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
		.timer_out_pin(timer_out_pin), .match_irq_zero(match_irq_zero),
		.match_irq_one(match_irq_one)
	);
	pin_model pin_model_i
	(
		.core_clk(core_clk), .lvl_a(lvl_a), .lvl_b(lvl_b),
		.capture_input_a(capture_input_a), .capture_input_b(capture_input_b)
	);

	////////////////////////////////////////////////////////////
	// Clock and event tally
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		n0 += match_irq_zero;
		n1 += match_irq_one;
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Expected values: one count clock per core clock in these scenarios
	function automatic logic [15:0] ticks_plus_one(input logic [15:0] n);
		return n + 16'h0001;
	endfunction
	// A restart clears to zero, so a capture n count clocks later holds n-1
	function automatic logic [15:0] since_restart(input logic [15:0] n);
		return n - 16'h0001;
	endfunction
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is taken in the one cycle that it stands
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Two back-to-back counter reads; returns their difference
	task step(output logic [15:0] d);
		logic [15:0] first;
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= `A_COUNTER;
		@(posedge core_clk);
		#1 first = reg_rdata;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata - first;
	endtask
	// Cycles until the output reaches a level, bounded so a stuck pin fails
	task hold(input logic lvl, output logic [15:0] n);
		n = 16'h0000;
		while (timer_out_pin !== lvl && n < 16'h00C8)
		begin
			@(posedge core_clk);
			#1 n++;
		end
		if (n == 16'h00C8)
			err_total++;
	endtask

	////////////////////////////////////////////////////////////
	initial
	begin
		k = $urandom(1722);
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (k = 0; k < 8; k++)
		begin
			rd(k[3:0], v);
			chk("reset value", v, 16'h0000);
		end
		// Free running: step of one, then a full wrap
		wr(`A_MODE, 16'h0004);
		repeat (8) @(posedge core_clk);
		step(v);
		chk("count step", v, 16'h0001);
		repeat (65536) @(posedge core_clk);
		rd(`A_MODE, v);
		chk("overflow set", v, 16'h0005);
		wr(`A_MODE, 16'h0004);
		rd(`A_MODE, v);
		chk("overflow clear", v, 16'h0004);
		wr(`A_MODE, 16'h0000);
		repeat (8) @(posedge core_clk);
		step(v);
		chk("count stopped", v, 16'h0000);
		// Pulse generator, width kept below cycle, both width extremes
		wr(`A_TOC, 16'h0013);
		for (k = 0; k < 4; k++)
		begin
			c = 16'h0002 + 16'($urandom_range(30));
			w = (k == 0) ? 16'h0000 : (k == 3) ? c - 16'h0001 : 16'($urandom_range(c - 1));
			wr(`A_MODE, 16'h0000);
			wr(`A_CYCLE, c);
			wr(`A_WIDTH, w);
			wr(`A_MODE, 16'h000C);
			hold(1'b0, t);
			hold(1'b1, t);
			hold(1'b0, t);
			chk("ppg high", t, ticks_plus_one(w));
			hold(1'b1, t);
			chk("ppg period", t + w + 16'h0001, ticks_plus_one(c));
		end
		// One-shot by trigger bit, then by a rising edge on a
		wr(`A_MODE, 16'h0000);
		wr(`A_TOC, 16'h0004);
		wr(`A_PRM, 16'h0005);
		wr(`A_CYCLE, 16'h0008);
		wr(`A_WIDTH, 16'h0003);
		wr(`A_MODE, 16'h0004);
		repeat (20) @(posedge core_clk);
		wr(`A_TOC, 16'h0033);
		for (k = 0; k < 2; k++)
		begin
			n0 = 0;
			n1 = 0;
			if (k == 0)
				wr(`A_TOC, 16'h0073);
			else
				@(posedge core_clk) lvl_a <= 1'b1;
			hold(1'b1, t);
			hold(1'b0, t);
			chk("oneshot width", t, 16'h0005);
			repeat (20) @(posedge core_clk);
			chk("oneshot events", 16'(n0 + 2 * n1), 16'h0003);
			chk("single pulse", {15'h0000, timer_out_pin}, 16'h0000);
		end
		// Two-input capture: a into width, b into cycle
		@(posedge core_clk) lvl_a <= 1'b0;
		wr(`A_TOC, 16'h0000);
		wr(`A_CRC, 16'h0005);
		t = 16'h0004 + 16'($urandom_range(40));
		n0 = 0;
		n1 = 0;
		@(posedge core_clk) lvl_a <= 1'b1;
		repeat (t) @(posedge core_clk);
		@(posedge core_clk) lvl_b <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(`A_CYCLE, c);
		rd(`A_WIDTH, w);
		chk("capture gap", c - w, ticks_plus_one(t));
		chk("capture events", 16'(n0 + 2 * n1), 16'h0003);
		// Restart on a: width takes the period, cycle the high time
		@(posedge core_clk);
		lvl_a <= 1'b0;
		lvl_b <= 1'b0;
		wr(`A_MODE, 16'h0000);
		wr(`A_CRC, 16'h0007);
		wr(`A_MODE, 16'h0008);
		c = 16'h0003 + 16'($urandom_range(20));
		w = 16'h0003 + 16'($urandom_range(20));
		n0 = 0;
		@(posedge core_clk) lvl_a <= 1'b1;
		repeat (c) @(posedge core_clk);
		@(posedge core_clk) lvl_a <= 1'b0;
		repeat (w) @(posedge core_clk);
		@(posedge core_clk) lvl_a <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(`A_CYCLE, v);
		chk("high time", v, since_restart(c + 16'h0001));
		rd(`A_WIDTH, v);
		chk("period", v, since_restart(c + w + 16'h0002));
		chk("opposite edge event", 16'(n0), 16'h0000);
		// Single input, free running: fall into cycle, rise into width
		wr(`A_MODE, 16'h0000);
		wr(`A_MODE, 16'h0004);
		@(posedge core_clk) lvl_a <= 1'b0;
		repeat (w) @(posedge core_clk);
		@(posedge core_clk) lvl_a <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(`A_CYCLE, t);
		rd(`A_WIDTH, v);
		chk("low time", v - t, ticks_plus_one(w));
		test_done();
	end

	// Guard against a hang; the run needs about 70k cycles
	initial
	begin
		#2ms;
		err_total++;
		test_done();
	end
endmodule // timer_ppg_oneshot_capture_tb
